// ---- pkg/ebc_pkg.sv ----
// shared constants and carrier types of the byte eeprom access control block
package ebc_pkg;

	// io register offsets, as seen by the cpu io instructions
	localparam logic [5:0] OFS_CONTROL      = 6'h1F;
	localparam logic [5:0] OFS_DATA         = 6'h20;
	localparam logic [5:0] OFS_ADDRESS_LOW  = 6'h21;
	localparam logic [5:0] OFS_ADDRESS_HIGH = 6'h22;

	// nv_control field positions
	localparam int BIT_READ_STROBE  = 0;
	localparam int BIT_WRITE_STROBE = 1;
	localparam int BIT_MASTER_WE    = 2;
	localparam int BIT_RDY_IRQ_EN   = 3;
	localparam int BIT_MODE_LO      = 4;
	localparam int BIT_MODE_HI      = 5;

	// nv_address layout: 12 bits over a low and a high byte
	localparam int ADDR_W     = 12;
	localparam int ADDR_LO_W  = 8;
	localparam int ADDR_HI_W  = ADDR_W - ADDR_LO_W;
	localparam int MAX_DEPTH  = 4096;

	// values
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] ZERO_BYTE   = 8'h00;

	// cpu clock and calibrated oscillator rates
	localparam int CLK_FREQ_KHZ = 200000;
	localparam int OSC_FREQ_KHZ = 8000;
	localparam int OSC_DIV      = CLK_FREQ_KHZ / OSC_FREQ_KHZ;

	// cpu-side timing, in cpu clock cycles
	localparam int MWE_WINDOW_CYCLES  = 4;
	localparam int WRITE_STALL_CYCLES = 2;
	localparam int READ_STALL_CYCLES  = 4;

	// programming times, typical, in microseconds
	localparam int PROG_TIME_CPU_US    = 3300;
	localparam int PROG_TIME_ATOMIC_US = 3400;
	localparam int PROG_TIME_SPLIT_US  = 1800;

	// programming lengths in oscillator cycles; split modes scale the atomic figure by time
	localparam int PROG_OSC_CYCLES_ATOMIC = 26368;
	localparam int PROG_OSC_CYCLES_SPLIT  = PROG_OSC_CYCLES_ATOMIC * PROG_TIME_SPLIT_US / PROG_TIME_ATOMIC_US;

	// programming modes
	typedef enum logic [1:0] {
		MODE_ATOMIC = 2'b00,
		MODE_ERASE  = 2'b01,
		MODE_WRITE  = 2'b10,
		MODE_RSVD   = 2'b11
	} ebc_mode_t;

	// read sequencer states
	typedef enum logic [1:0] {
		RD_IDLE  = 2'b00,
		RD_FETCH = 2'b01,
		RD_LOAD  = 2'b10
	} ebc_rd_state_t;

	// one io register bus request
	typedef struct packed {
		logic       we;
		logic       re;
		logic [5:0] addr;
		logic [7:0] wdata;
	} ebc_io_req_t;

	// one programming command handed to the engine
	typedef struct packed {
		ebc_mode_t         mode;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} ebc_prog_cmd_t;

	// cpu-side register state
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
		ebc_mode_t         mode;
		logic              rdy_ie;
		logic              mwe;
		logic [2:0]        mwe_cnt;
		ebc_rd_state_t     rd;
		logic [2:0]        stall;
		logic [7:0]        rdata;
	} ebc_ctl_t;

	localparam ebc_ctl_t CTL_RESET = ebc_ctl_t'('0);

endpackage

// ---- verilog/ebc_nv_array.sv ----
// byte array of the data eeprom with a registered read port and a mode-aware write port
`timescale 1ns/100ps
module ebc_nv_array #(
	parameter int DEPTH = 4096,
	parameter int AW    = 12
) (
	input  wire logic              clock_i,
	input  wire logic              rstn_i,
	input  wire logic              rd_en_i,
	input  wire logic [AW-1:0]     rd_addr_i,
	output logic      [7:0]        rd_data_o,
	input  wire logic              wr_en_i,
	input  wire ebc_pkg::ebc_mode_t wr_mode_i,
	input  wire logic [AW-1:0]     wr_addr_i,
	input  wire logic [7:0]        wr_data_i
);
	import ebc_pkg::*;

	logic [7:0] cells [DEPTH];
	logic [7:0] rd_data_ff;

	// cells carry no reset: their contents survive any reset
	always_ff @(posedge clock_i) begin
		if (wr_en_i) begin
			unique case (wr_mode_i)
				MODE_ATOMIC: cells[wr_addr_i] <= wr_data_i;
				MODE_ERASE:  cells[wr_addr_i] <= ERASED_BYTE;
				MODE_WRITE:  cells[wr_addr_i] <= cells[wr_addr_i] & wr_data_i; // write only clears bits
				MODE_RSVD:   cells[wr_addr_i] <= cells[wr_addr_i];
			endcase
		end
	end

	// read data leave through a register
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_ff <= ZERO_BYTE;
		end else if (rd_en_i) begin
			rd_data_ff <= cells[rd_addr_i];
		end
	end

	assign rd_data_o = rd_data_ff;

endmodule

// ---- verilog/ebc_prog_engine.sv ----
// programming engine: latches a command and times it from the oscillator tick
`timescale 1ns/100ps
module ebc_prog_engine #(
	parameter int PROG_ATOMIC = ebc_pkg::PROG_OSC_CYCLES_ATOMIC,
	parameter int PROG_SPLIT  = ebc_pkg::PROG_OSC_CYCLES_SPLIT,
	parameter int OSC_DIV     = ebc_pkg::OSC_DIV
) (
	input  wire logic                   clock_i,
	input  wire logic                   por_rstn_i,
	input  wire logic                   start_i,
	input  wire ebc_pkg::ebc_prog_cmd_t cmd_i,
	output logic                        busy_o,
	output ebc_pkg::ebc_prog_cmd_t      cmd_o,
	output logic                        commit_o
);
	import ebc_pkg::*;

	localparam int CW = $clog2(PROG_ATOMIC + 1);
	localparam int DW = $clog2(OSC_DIV + 1);

	typedef enum logic {
		ENG_IDLE = 1'b0,
		ENG_BUSY = 1'b1
	} ebc_eng_state_t;

	typedef struct packed {
		ebc_eng_state_t st;
		logic [DW-1:0]  div;
		logic [CW-1:0]  left;
		ebc_prog_cmd_t  cmd;
	} ebc_eng_t;

	ebc_eng_t state_ff;
	ebc_eng_t nxt_state;

	if (PROG_ATOMIC < 1 || PROG_SPLIT < 1 || PROG_SPLIT > PROG_ATOMIC || OSC_DIV < 1) begin : g_bad_cfg
		$error("ebc_prog_engine: programming lengths or oscillator divider out of range");
	end

	// divider makes the oscillator tick; the length counts ticks down to the commit
	always_comb begin
		nxt_state = state_ff;
		commit_o  = 1'b0;
		unique case (state_ff.st)
			ENG_IDLE: begin
				if (start_i) begin
					nxt_state.st   = ENG_BUSY;
					nxt_state.cmd  = cmd_i;
					nxt_state.div  = '0;
					nxt_state.left = (cmd_i.mode == MODE_ATOMIC) ? CW'(PROG_ATOMIC) : CW'(PROG_SPLIT);
				end
			end
			ENG_BUSY: begin
				if (state_ff.div == DW'(OSC_DIV - 1)) begin
					nxt_state.div = '0;
					if (state_ff.left == CW'(1)) begin
						commit_o       = 1'b1;
						nxt_state.st   = ENG_IDLE;
						nxt_state.left = '0;
					end else begin
						nxt_state.left = state_ff.left - CW'(1);
					end
				end else begin
					nxt_state.div = state_ff.div + DW'(1);
				end
			end
		endcase
	end

	// only the supply reset stops a running operation; the cpu reset never reaches here
	always_ff @(posedge clock_i or negedge por_rstn_i) begin
		if (!por_rstn_i) begin
			state_ff <= ebc_eng_t'('0);
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign busy_o = (state_ff.st == ENG_BUSY);
	assign cmd_o  = state_ff.cmd;

endmodule

// ---- verilog/ebc_top.sv ----
// cpu-facing register control of the byte-wide data eeprom
`timescale 1ns/100ps
module ebc_top #(
	parameter int DEPTH                  = ebc_pkg::MAX_DEPTH,
	parameter int PROG_OSC_CYCLES_ATOMIC = ebc_pkg::PROG_OSC_CYCLES_ATOMIC,
	parameter int PROG_OSC_CYCLES_SPLIT  = ebc_pkg::PROG_OSC_CYCLES_SPLIT,
	parameter int OSC_DIV                = ebc_pkg::OSC_DIV
) (
	input  wire logic                 clock_i,
	input  wire logic                 rstn_i,
	input  wire logic                 por_rstn_i,
	input  wire ebc_pkg::ebc_io_req_t io_req_i,
	output logic      [7:0]           io_rdata_o,
	input  wire logic                 global_irq_en_i,
	input  wire logic                 self_prog_active_i,
	output logic                      cpu_stall_o,
	output logic                      ready_irq_o
);
	import ebc_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// only the documented array sizes are served
	if (DEPTH != 512 && DEPTH != 1024 && DEPTH != 2048 && DEPTH != MAX_DEPTH) begin : g_bad_depth
		$error("ebc_top: DEPTH must be 512, 1024, 2048 or 4096");
	end
	if (OSC_DIV < 1) begin : g_bad_div
		$error("ebc_top: OSC_DIV must be at least one");
	end

	ebc_ctl_t      ctl_ff;
	ebc_ctl_t      nxt_ctl;

	logic          eng_start;
	logic          eng_busy;
	logic          eng_commit;
	ebc_prog_cmd_t eng_cmd;
	ebc_prog_cmd_t eng_cmd_q;

	logic          mem_rd_en;
	logic [7:0]    mem_rd_data;

	logic          ctl_wr;
	logic          rd_pending;
	logic          wr_go;
	logic          rd_go;
	ebc_mode_t     mode_view;
	logic [7:0]    ctl_view;

	// decode of a write to one io offset
	function automatic logic reg_write(input ebc_io_req_t req, input logic [5:0] ofs);
		reg_write = req.we && (req.addr == ofs);
	endfunction

	// decode of a read of one io offset
	function automatic logic reg_read(input ebc_io_req_t req, input logic [5:0] ofs);
		reg_read = req.re && (req.addr == ofs);
	endfunction

	// the running operation keeps its own mode, so a cpu reset cannot disturb it
	assign mode_view = eng_busy ? eng_cmd_q.mode : ctl_ff.mode;
	assign rd_pending = (ctl_ff.rd != RD_IDLE);

	// control register as software sees it
	always_comb begin
		ctl_view                   = ZERO_BYTE;
		ctl_view[BIT_MODE_HI]      = mode_view[1];
		ctl_view[BIT_MODE_LO]      = mode_view[0];
		ctl_view[BIT_RDY_IRQ_EN]   = ctl_ff.rdy_ie;
		ctl_view[BIT_MASTER_WE]    = ctl_ff.mwe;
		ctl_view[BIT_WRITE_STROBE] = eng_busy;
		ctl_view[BIT_READ_STROBE]  = rd_pending;
	end

	// a strobe starts programming only inside the enable window, never over flash work
	assign ctl_wr = reg_write(io_req_i, OFS_CONTROL);
	assign wr_go  = ctl_wr && io_req_i.wdata[BIT_WRITE_STROBE] && ctl_ff.mwe
	                && !eng_busy && !self_prog_active_i
	                && !rd_pending && (nxt_ctl.mode != MODE_RSVD);

	// a read strobe is refused while programming is under way
	assign rd_go = ctl_wr && io_req_i.wdata[BIT_READ_STROBE] && !wr_go
	               && !eng_busy && !rd_pending;

	// next register state
	always_comb begin
		nxt_ctl   = ctl_ff;
		mem_rd_en = 1'b0;

		// cpu stall countdown
		if (ctl_ff.stall != 3'h0) begin
			nxt_ctl.stall = ctl_ff.stall - 3'h1;
		end

		// master enable expires on its own; a late strobe then finds it clear
		if (ctl_ff.mwe) begin
			if (ctl_ff.mwe_cnt == 3'h0) begin
				nxt_ctl.mwe = 1'b0;
			end else begin
				nxt_ctl.mwe_cnt = ctl_ff.mwe_cnt - 3'h1;
			end
		end

		// address writes are held off while programming or a fetch uses the address
		if (reg_write(io_req_i, OFS_ADDRESS_LOW) && !eng_busy && !rd_pending) begin
			nxt_ctl.addr[ADDR_LO_W-1:0] = io_req_i.wdata;
		end
		if (reg_write(io_req_i, OFS_ADDRESS_HIGH) && !eng_busy && !rd_pending) begin
			nxt_ctl.addr[ADDR_W-1:ADDR_LO_W] = io_req_i.wdata[ADDR_HI_W-1:0];
		end

		// data register takes the byte to be programmed
		if (reg_write(io_req_i, OFS_DATA)) begin
			nxt_ctl.data = io_req_i.wdata;
		end

		// control register write
		if (ctl_wr) begin
			nxt_ctl.rdy_ie = io_req_i.wdata[BIT_RDY_IRQ_EN];
			if (!eng_busy) begin
				nxt_ctl.mode = ebc_mode_t'(io_req_i.wdata[BIT_MODE_HI:BIT_MODE_LO]);
			end
			// a rewrite of one keeps the window running; a fresh set restarts it
			if (io_req_i.wdata[BIT_MASTER_WE] && !ctl_ff.mwe) begin
				nxt_ctl.mwe     = 1'b1;
				nxt_ctl.mwe_cnt = 3'(MWE_WINDOW_CYCLES - 1);
			end else if (!io_req_i.wdata[BIT_MASTER_WE]) begin
				nxt_ctl.mwe = 1'b0;
			end
		end

		// stall lengths for the two kinds of access
		if (wr_go) begin
			nxt_ctl.stall = 3'(WRITE_STALL_CYCLES);
		end
		if (rd_go) begin
			nxt_ctl.rd    = RD_FETCH;
			nxt_ctl.stall = 3'(READ_STALL_CYCLES);
		end

		// read sequencer: fetch the array, then load the data register
		unique case (ctl_ff.rd)
			RD_IDLE: begin
			end
			RD_FETCH: begin
				mem_rd_en  = 1'b1;
				nxt_ctl.rd = RD_LOAD;
			end
			RD_LOAD: begin
				nxt_ctl.data = mem_rd_data;
				nxt_ctl.rd   = RD_IDLE;
			end
			default: begin
				nxt_ctl.rd = RD_IDLE;
			end
		endcase

		// registered read data; unmapped offsets answer zero
		if (io_req_i.re) begin
			nxt_ctl.rdata = ZERO_BYTE;
			if (reg_read(io_req_i, OFS_CONTROL)) begin
				nxt_ctl.rdata = ctl_view;
			end
			if (reg_read(io_req_i, OFS_DATA)) begin
				nxt_ctl.rdata = ctl_ff.data;
			end
			if (reg_read(io_req_i, OFS_ADDRESS_LOW)) begin
				nxt_ctl.rdata = ctl_ff.addr[ADDR_LO_W-1:0];
			end
			if (reg_read(io_req_i, OFS_ADDRESS_HIGH)) begin
				nxt_ctl.rdata = {{(8 - ADDR_HI_W){1'b0}}, ctl_ff.addr[ADDR_W-1:ADDR_LO_W]};
			end
		end
	end

	// command for the engine: mode as written in this same access
	always_comb begin
		eng_start    = wr_go;
		eng_cmd.mode = nxt_ctl.mode;
		eng_cmd.addr = ctl_ff.addr;
		eng_cmd.data = ctl_ff.data;
	end

	// cpu-side state; reset brings mode to atomic, the engine keeps its own copy
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctl_ff <= CTL_RESET;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	// programming engine on the supply reset only
	ebc_prog_engine #(
		.PROG_ATOMIC (PROG_OSC_CYCLES_ATOMIC),
		.PROG_SPLIT  (PROG_OSC_CYCLES_SPLIT),
		.OSC_DIV     (OSC_DIV)
	) u_engine (
		.clock_i    (clock_i),
		.por_rstn_i (por_rstn_i),
		.start_i    (eng_start),
		.cmd_i      (eng_cmd),
		.busy_o     (eng_busy),
		.cmd_o      (eng_cmd_q),
		.commit_o   (eng_commit)
	);

	// the array sees only the low address bits its size needs
	ebc_nv_array #(
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_array (
		.clock_i   (clock_i),
		.rstn_i    (rstn_i),
		.rd_en_i   (mem_rd_en),
		.rd_addr_i (ctl_ff.addr[AW-1:0]),
		.rd_data_o (mem_rd_data),
		.wr_en_i   (eng_commit),
		.wr_mode_i (eng_cmd_q.mode),
		.wr_addr_i (eng_cmd_q.addr[AW-1:0]),
		.wr_data_i (eng_cmd_q.data)
	);

	// outputs
	assign io_rdata_o  = ctl_ff.rdata;
	assign cpu_stall_o = (ctl_ff.stall != 3'h0);
	assign ready_irq_o = ctl_ff.rdy_ie && global_irq_en_i && !eng_busy;

endmodule

// ---- tb/ebc_monitor.sv ----
// assertion checker on the ports of the eeprom access control block
`timescale 1ns/100ps
module ebc_monitor (
	input wire logic                 clock_i,
	input wire logic                 rstn_i,
	input wire ebc_pkg::ebc_io_req_t io_req_i,
	input wire logic [7:0]           io_rdata_o,
	input wire logic                 global_irq_en_i,
	input wire logic                 self_prog_active_i,
	input wire logic                 cpu_stall_o,
	input wire logic                 ready_irq_o
);
	import ebc_pkg::*;
	logic ctl_wr;
	logic ctl_rd;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	// control register accesses
	assign ctl_wr = io_req_i.we && io_req_i.addr == OFS_CONTROL;
	assign ctl_rd = io_req_i.re && io_req_i.addr == OFS_CONTROL;
	a_irq_needs_gie: assert property (ready_irq_o |-> global_irq_en_i)
		else $error("ready interrupt without global enable");
	a_stall_length: assert property ($rose(cpu_stall_o) |-> cpu_stall_o[*2] ##1
		(!cpu_stall_o or cpu_stall_o[*2] ##1 !cpu_stall_o))
		else $error("stall neither two nor four cycles");
	a_stall_cause: assert property ($rose(cpu_stall_o) |->
		$past(ctl_wr && io_req_i.wdata[1:0] != 2'b00))
		else $error("stall without a strobe write");
	a_ctl_reserved: assert property (ctl_rd |=> io_rdata_o[7:6] == 2'b00)
		else $error("control reserved bits not zero");
	a_addr_reserved: assert property (io_req_i.re && io_req_i.addr == OFS_ADDRESS_HIGH
		|=> io_rdata_o[7:4] == 4'h0)
		else $error("address high reserved bits not zero");
	a_rdata_holds: assert property (!io_req_i.re |=> $stable(io_rdata_o))
		else $error("read data moved without a read");
	a_mwe_live: assert property (ctl_wr && io_req_i.wdata[2:1] == 2'b10 ##1 !io_req_i.we
		##1 ctl_rd |=> io_rdata_o[2])
		else $error("master enable gone too early");
	a_mwe_expire: assert property (ctl_wr && io_req_i.wdata[2:1] == 2'b10 ##1 (!io_req_i.we)[*4] ##1 ctl_rd
		|=> !io_rdata_o[2])
		else $error("master enable not cleared after four cycles");
	a_flash_blocks: assert property (self_prog_active_i && !cpu_stall_o && ctl_wr
		&& io_req_i.wdata[1:0] == 2'b10 |=> !cpu_stall_o)
		else $error("write started during flash programming");
endmodule

// ---- tb/ebc_cpu_model.sv ----
// cpu model reaching the eeprom registers over the io register bus
`timescale 1ns/100ps
module ebc_cpu_model (
	input  wire logic           clock_i,
	input  wire logic [7:0]     io_rdata_i,
	input  wire logic           cpu_stall_i,
	output ebc_pkg::ebc_io_req_t io_req_o,
	output logic                gie_o,
	output logic                spm_o
);
	import ebc_pkg::*;
	// idle bus, interrupts off, no flash programming
	initial begin
		io_req_o = '0;
		gie_o = 1'b0;
		spm_o = 1'b0;
	end
	// one bus cycle; a halted core issues nothing until the stall ends or eight more cycles have passed
	task automatic start(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clock_i);
		while (cpu_stall_i !== 1'b0 && n < 8) begin
			@(negedge clock_i);
			n++;
		end
		io_req_o = '{we: w, re: !w, addr: a, wdata: d};
		@(negedge clock_i);
		io_req_o.we = 1'b0;
		io_req_o.re = 1'b0;
		io_req_o.wdata = ~d; // released data must not look valid
	endtask
	task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
		start(1'b1, a, d);
	endtask
	task automatic io_rd(input logic [5:0] a, output logic [7:0] v);
		start(1'b0, a, 8'h00);
		v = io_rdata_i;
	endtask
	// full byte write, returning right after the strobe is written
	task automatic ee_write(input logic [11:0] a, input logic [7:0] d, input ebc_mode_t m, output bit ok);
		logic [7:0] v;
		int n;
		n = 0;
		v = 8'h02;
		while (v[1] !== 1'b0 && n < 40) begin
			io_rd(OFS_CONTROL, v);
			n++;
		end
		ok = v[1] === 1'b0 && !spm_o;
		if (ok) begin
			gie_o = 1'b0;
			io_wr(OFS_ADDRESS_LOW, a[7:0]);
			io_wr(OFS_ADDRESS_HIGH, {4'h0, a[11:8]});
			io_wr(OFS_DATA, d);
			io_wr(OFS_CONTROL, {2'b00, m, 4'hC});
			io_wr(OFS_CONTROL, {2'b00, m, 4'hE});
		end
	endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking testbench of the eeprom access control block
`timescale 1ns/100ps
module tb_top;
	import ebc_pkg::*;
	logic        clock_i;
	logic        rstn_i;
	logic        por_rstn_i;
	ebc_io_req_t io_req;
	logic [7:0]  io_rdata_o;
	logic        gie;
	logic        spm;
	logic        cpu_stall_o;
	logic        ready_irq_o;
	logic [7:0]  v;
	bit          ok;
	int          failures = 0;
	int          total_checks = 0;
	ebc_mode_t   md [3] = '{MODE_ATOMIC, MODE_WRITE, MODE_ERASE};
	logic [7:0]  dt [3] = '{8'hF0, 8'h3C, 8'h00};
	logic [7:0]  ex [3] = '{8'hF0, 8'h30, 8'hFF};
	// short programming counts keep the run brief: atomic 16, split 8 cycles
	ebc_top #(.PROG_OSC_CYCLES_ATOMIC(8), .PROG_OSC_CYCLES_SPLIT(4), .OSC_DIV(2)) ebc_top_inst (
		.clock_i(clock_i), .rstn_i(rstn_i), .por_rstn_i(por_rstn_i), .io_req_i(io_req),
		.io_rdata_o(io_rdata_o), .global_irq_en_i(gie), .self_prog_active_i(spm),
		.cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o));
	ebc_cpu_model ebc_cpu_model_inst (.clock_i(clock_i), .io_rdata_i(io_rdata_o), .cpu_stall_i(cpu_stall_o),
		.io_req_o(io_req), .gie_o(gie), .spm_o(spm));
	// 200 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		ebc_cpu_model_inst.io_wr(a, d);
	endtask
	task automatic rdc(input string n, input logic [5:0] a, input logic [7:0] e);
		ebc_cpu_model_inst.io_rd(a, v);
		chk(n, e, v);
	endtask
	// bounded poll of the write strobe; running out ends the run
	task automatic idle();
		v = 8'h02;
		for (int n = 0; n < 40 && v[1] !== 1'b0; n++) begin
			ebc_cpu_model_inst.io_rd(OFS_CONTROL, v);
		end
		chk("strobe cleared", 8'h00, {6'h0, v[1], 1'b0});
		if (v[1] !== 1'b0) give_verdict();
	endtask
	// byte write sequence; a strobe that never cleared counts as a mismatch
	task automatic ew(input logic [11:0] a, input logic [7:0] d, input ebc_mode_t m);
		ebc_cpu_model_inst.ee_write(a, d, m, ok);
		chk("write issued", 8'h01, 8'(ok));
	endtask
	task automatic prog(input logic [11:0] a, input logic [7:0] d, input ebc_mode_t m, input logic [7:0] e);
		ew(a, d, m);
		idle();
		wr(OFS_CONTROL, 8'h01);
		rdc("read back", OFS_DATA, e);
	endtask
	task automatic t_regs();
		rdc("control reset", OFS_CONTROL, 8'h00);
		wr(OFS_ADDRESS_HIGH, 8'hFF);
		rdc("addr high", OFS_ADDRESS_HIGH, 8'h0F);
		wr(OFS_CONTROL, 8'hC8);
		rdc("control", OFS_CONTROL, 8'h08);
		ebc_cpu_model_inst.gie_o = 1'b1;
		#1 chk("irq on", 8'h01, 8'(ready_irq_o));
		wr(OFS_CONTROL, 8'h00);
		chk("irq off", 8'h00, 8'(ready_irq_o));
		rdc("unmapped", 6'h10, 8'h00);
	endtask
	task automatic t_write();
		ew(12'h123, 8'h5A, MODE_ATOMIC);
		chk("stall w1", 8'h01, 8'(cpu_stall_o));
		ebc_cpu_model_inst.gie_o = 1'b1;
		@(negedge clock_i);
		chk("stall w2", 8'h01, 8'(cpu_stall_o));
		@(negedge clock_i);
		chk("stall w3", 8'h00, 8'(cpu_stall_o));
		chk("irq busy", 8'h00, 8'(ready_irq_o));
		repeat (6) @(negedge clock_i);
		rdc("control busy", OFS_CONTROL, 8'h0A);
		idle();
		chk("irq ready", 8'h01, 8'(ready_irq_o));
		ebc_cpu_model_inst.gie_o = 1'b0;
		wr(OFS_CONTROL, 8'h09);
		chk("stall r1", 8'h01, 8'(cpu_stall_o));
		repeat (3) @(negedge clock_i);
		chk("stall r4", 8'h01, 8'(cpu_stall_o));
		@(negedge clock_i);
		chk("stall r5", 8'h00, 8'(cpu_stall_o));
		rdc("data", OFS_DATA, 8'h5A);
		rdc("read strobe", OFS_CONTROL, 8'h08);
	endtask
	task automatic t_modes();
		for (int i = 0; i < 3; i++) begin
			prog(12'h0A5, dt[i], md[i], ex[i]);
		end
		ew(12'h0A5, 8'h00, MODE_RSVD);
		repeat (4) @(negedge clock_i);
		rdc("reserved mode", OFS_CONTROL, 8'h38);
		wr(OFS_CONTROL, 8'h01);
		rdc("unchanged", OFS_DATA, 8'hFF);
	endtask
	task automatic t_mwe();
		wr(OFS_CONTROL, 8'h04);
		rdc("enable live", OFS_CONTROL, 8'h04);
		wr(OFS_CONTROL, 8'h04);
		repeat (3) @(negedge clock_i);
		rdc("enable expired", OFS_CONTROL, 8'h00);
		wr(OFS_CONTROL, 8'h02);
		chk("late stall", 8'h00, 8'(cpu_stall_o));
		rdc("late strobe", OFS_CONTROL, 8'h00);
	endtask
	task automatic t_busy();
		ew(12'h010, 8'h11, MODE_ATOMIC);
		wr(OFS_CONTROL, 8'h39);
		wr(OFS_ADDRESS_LOW, 8'h55);
		rdc("control held", OFS_CONTROL, 8'h0A);
		rdc("addr held", OFS_ADDRESS_LOW, 8'h10);
		idle();
		wr(OFS_CONTROL, 8'h09);
		rdc("busy data", OFS_DATA, 8'h11);
	endtask
	task automatic t_spm();
		ebc_cpu_model_inst.spm_o = 1'b1;
		wr(OFS_CONTROL, 8'h04);
		wr(OFS_CONTROL, 8'h06);
		chk("flash stall", 8'h00, 8'(cpu_stall_o));
		rdc("flash control", OFS_CONTROL, 8'h04);
		ebc_cpu_model_inst.spm_o = 1'b0;
	endtask
	task automatic t_reset();
		ew(12'h020, 8'h00, MODE_ERASE);
		rstn_i = 1'b0;
		repeat (2) @(negedge clock_i);
		rstn_i = 1'b1;
		rdc("control kept", OFS_CONTROL, 8'h12);
		idle();
		wr(OFS_ADDRESS_LOW, 8'h20);
		wr(OFS_ADDRESS_HIGH, 8'h00);
		wr(OFS_CONTROL, 8'h01);
		rdc("erased", OFS_DATA, 8'hFF);
		// leave a non-zero mode behind so the reset has something to clear
		wr(OFS_CONTROL, 8'h20);
		rdc("mode set", OFS_CONTROL, 8'h20);
		rstn_i = 1'b0;
		@(negedge clock_i);
		rstn_i = 1'b1;
		rdc("mode reset", OFS_CONTROL, 8'h00);
	endtask
	// main sequence
	initial begin
		rstn_i = 1'b0;
		por_rstn_i = 1'b0;
		repeat (12) @(negedge clock_i);
		rstn_i = 1'b1;
		por_rstn_i = 1'b1;
		t_regs();
		t_write();
		t_modes();
		t_mwe();
		t_busy();
		t_spm();
		t_reset();
		give_verdict();
	end
endmodule
bind ebc_top ebc_monitor ebc_monitor_inst (.clock_i(clock_i), .rstn_i(rstn_i), .io_req_i(io_req_i),
	.io_rdata_o(io_rdata_o), .global_irq_en_i(global_irq_en_i), .self_prog_active_i(self_prog_active_i),
	.cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o));
